/* File: msob_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module msob_bank
   import msob_pkg::*;
#(
   parameter int unsigned ADDR_W = 32
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire msob_setpoint_t setpoint_in,
   input wire logic ip_mode_active,
   input wire logic sync_pin,
   output msob_setpoint_t cmd_out,
   output msob_vel_unit_t vel_unit,
   output logic [31:0] interp_target,
   output logic interp_target_valid,
   output logic [31:0] cycle_time_us
);

   if (ADDR_W < ADDR_W_MIN) begin : g_bad_addr_w
      $error("ADDR_W too narrow for the register map");
   end

   // register file
   logic [31:0] vel_unit_word, next_vel_unit_word;
   logic signed [31:0] position_setpoint_offset, next_position_setpoint_offset;
   logic signed [31:0] speed_setpoint_offset, next_speed_setpoint_offset;
   logic signed [15:0] torque_setpoint_offset, next_torque_setpoint_offset;
   logic [31:0] interp_demand_position, next_interp_demand_position;
   logic [7:0] interp_period_value, next_interp_period_value;
   logic signed [7:0] interp_period_exponent, next_interp_period_exponent;

   // bus state
   logic wr_act, next_wr_act;
   msob_reg_t wr_sel, next_wr_sel, addr_sel;
   logic addr_ok;
   logic [31:0] next_hrdata;

   // datapath outputs
   msob_setpoint_t next_cmd_out;
   msob_vel_unit_t next_vel_unit;

   // submodule results
   logic demand_pending, range_err, exp_not_ms, demand_load;
   logic [31:0] status_word;

   function automatic msob_reg_t decode(input logic [ADDR_W-1:0] a);
      logic [31:0] a32;
      a32 = 32'(a);
      if (a32 == msob_byte_addr(IDX_VEL_UNIT)) return MSOB_R_VEL;
      else if (a32 == msob_byte_addr(IDX_POS_OFFSET)) return MSOB_R_POS;
      else if (a32 == msob_byte_addr(IDX_SPD_OFFSET)) return MSOB_R_SPD;
      else if (a32 == msob_byte_addr(IDX_TRQ_OFFSET)) return MSOB_R_TRQ;
      else if (a32 == msob_byte_addr(IDX_DEMAND_POS)) return MSOB_R_DEMAND;
      else if (a32 == msob_byte_addr(IDX_PERIOD_VAL)) return MSOB_R_PVAL;
      else if (a32 == msob_byte_addr(IDX_PERIOD_EXP)) return MSOB_R_PEXP;
      else if (a32 == msob_byte_addr(IDX_STATUS)) return MSOB_R_STATUS;
      else if (a32 == msob_byte_addr(IDX_ACTIVE_TGT)) return MSOB_R_ACTIVE;
      else if (a32 == msob_byte_addr(IDX_CYCLE_US)) return MSOB_R_CYCLE;
      else return MSOB_R_NONE;
   endfunction

   // torque clamps at the int16 limits rather than wrapping sign
   function automatic logic signed [15:0] sat_add16(input logic signed [15:0] a,
                                                    input logic signed [15:0] b);
      logic signed [16:0] s;
      s = 17'(a) + 17'(b);
      if (s[16] != s[15]) return s[16] ? 16'sh8000 : 16'sh7FFF;
      else return s[15:0];
   endfunction

   // address phase decode
   always_comb begin
      addr_ok = hsel && hready && htrans[1];
      addr_sel = decode(haddr);
      next_wr_act = addr_ok && hwrite;
      next_wr_sel = addr_ok ? addr_sel : MSOB_R_NONE;
      demand_load = wr_act && (wr_sel == MSOB_R_DEMAND);
   end

   // data phase writes; read-only and unmapped targets ignore data
   always_comb begin
      next_vel_unit_word = vel_unit_word;
      next_position_setpoint_offset = position_setpoint_offset;
      next_speed_setpoint_offset = speed_setpoint_offset;
      next_torque_setpoint_offset = torque_setpoint_offset;
      next_interp_demand_position = interp_demand_position;
      next_interp_period_value = interp_period_value;
      next_interp_period_exponent = interp_period_exponent;
      if (wr_act) begin
         case (wr_sel)
            MSOB_R_VEL: begin
               next_vel_unit_word = {hwdata[31:VEL_TIME_LSB], 8'h00};
            end
            MSOB_R_POS: next_position_setpoint_offset = hwdata;
            MSOB_R_SPD: next_speed_setpoint_offset = hwdata;
            MSOB_R_TRQ: next_torque_setpoint_offset = hwdata[15:0];
            MSOB_R_DEMAND: next_interp_demand_position = hwdata;
            MSOB_R_PVAL: next_interp_period_value = hwdata[7:0];
            MSOB_R_PEXP: next_interp_period_exponent = hwdata[7:0];
            default: ;
         endcase
      end
   end

   // read mux uses next values so a read right behind a write sees it
   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_PENDING] = demand_pending;
      status_word[ST_EXP_NOT_MS] = exp_not_ms;
      status_word[ST_RANGE_ERR] = range_err;
      next_hrdata = 32'h00000000;
      if (addr_ok && !hwrite) begin
         case (addr_sel)
            MSOB_R_VEL: next_hrdata = next_vel_unit_word;
            MSOB_R_POS: next_hrdata = next_position_setpoint_offset;
            MSOB_R_SPD: next_hrdata = next_speed_setpoint_offset;
            MSOB_R_TRQ: next_hrdata = {16'h0000, next_torque_setpoint_offset};
            MSOB_R_DEMAND: next_hrdata = next_interp_demand_position;
            MSOB_R_PVAL: next_hrdata = {24'h000000, next_interp_period_value};
            MSOB_R_PEXP: next_hrdata = {24'h000000, next_interp_period_exponent};
            MSOB_R_STATUS: next_hrdata = status_word;
            MSOB_R_ACTIVE: next_hrdata = interp_target;
            MSOB_R_CYCLE: next_hrdata = cycle_time_us;
            default: next_hrdata = 32'h00000000;
         endcase
      end
   end

   // offset adders: corrected commands, one cycle behind the set values
   always_comb begin
      next_cmd_out.position = setpoint_in.position + position_setpoint_offset;
      next_cmd_out.speed = setpoint_in.speed + speed_setpoint_offset;
      next_cmd_out.torque = sat_add16(setpoint_in.torque, torque_setpoint_offset);
      next_vel_unit.exponent = vel_unit_word[VEL_EXP_LSB +: VEL_FIELD_W];
      next_vel_unit.pos_unit = vel_unit_word[VEL_POS_LSB +: VEL_FIELD_W];
      next_vel_unit.time_unit = vel_unit_word[VEL_TIME_LSB +: VEL_FIELD_W];
   end

   // registers; ready and response never change, zero wait states
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         vel_unit_word <= RST_VEL_UNIT;
         position_setpoint_offset <= RST_OFFSET32;
         speed_setpoint_offset <= RST_OFFSET32;
         torque_setpoint_offset <= RST_OFFSET16;
         interp_demand_position <= RST_DEMAND;
         interp_period_value <= RST_PERIOD_VAL;
         interp_period_exponent <= RST_PERIOD_EXP;
         wr_act <= 1'b0;
         wr_sel <= MSOB_R_NONE;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         cmd_out <= '0;
         vel_unit <= '0;
      end else if (ce) begin
         vel_unit_word <= next_vel_unit_word;
         position_setpoint_offset <= next_position_setpoint_offset;
         speed_setpoint_offset <= next_speed_setpoint_offset;
         torque_setpoint_offset <= next_torque_setpoint_offset;
         interp_demand_position <= next_interp_demand_position;
         interp_period_value <= next_interp_period_value;
         interp_period_exponent <= next_interp_period_exponent;
         wr_act <= next_wr_act;
         wr_sel <= next_wr_sel;
         hrdata <= next_hrdata;
         cmd_out <= next_cmd_out;
         vel_unit <= next_vel_unit;
      end
   end

   // sync pin is asynchronous; the capture block synchronises it
   msob_sync_capture u_capture (
      .ref_clk(ref_clk),
      .srst(srst),
      .ce(ce),
      .sync_pin(sync_pin),
      .load(demand_load),
      .demand(interp_demand_position),
      .mode_active(ip_mode_active),
      .target(interp_target),
      .target_valid(interp_target_valid),
      .pending(demand_pending)
   );

   msob_cycle_time u_cycle (
      .ref_clk(ref_clk),
      .srst(srst),
      .ce(ce),
      .period_value(interp_period_value),
      .period_exp(interp_period_exponent),
      .cycle_us(cycle_time_us),
      .range_err(range_err),
      .exp_not_ms(exp_not_ms)
   );

   chk_vel_rsvd_zero: assert property (@(posedge ref_clk) disable iff (srst)
      vel_unit_word[VEL_RSVD_MSB:0] == 8'h00) else $error("velocity low byte not zero");

   chk_vel_fields: assert property (@(posedge ref_clk) disable iff (srst)
      ce && wr_act && wr_sel == MSOB_R_VEL |=>
         vel_unit_word[31:VEL_TIME_LSB] == $past(hwdata[31:VEL_TIME_LSB]) ##1
         (!$past(ce) ||
          vel_unit.time_unit == $past(vel_unit_word[VEL_TIME_LSB +: VEL_FIELD_W])))
      else $error("velocity fields not stored");

   chk_pos_offset: assert property (@(posedge ref_clk) disable iff (srst)
      ce |=> cmd_out.position == $past(setpoint_in.position) + $past(position_setpoint_offset))
      else $error("position offset not applied");

   chk_spd_offset: assert property (@(posedge ref_clk) disable iff (srst)
      ce |=> cmd_out.speed == $past(setpoint_in.speed) + $past(speed_setpoint_offset))
      else $error("speed offset not applied");

   chk_trq_offset: assert property (@(posedge ref_clk) disable iff (srst)
      ce && setpoint_in.torque[15] != torque_setpoint_offset[15] |=>
         cmd_out.torque == $past(setpoint_in.torque) + $past(torque_setpoint_offset))
      else $error("torque offset not applied");

   chk_ahb_okay: assert property (@(posedge ref_clk) disable iff (srst)
      hreadyout && !hresp) else $error("slave left OKAY zero-wait");

   chk_demand_shadow: assert property (@(posedge ref_clk) disable iff (srst)
      ce && demand_load |=> interp_target == $past(interp_target) ||
         (interp_target_valid && interp_target == $past(interp_demand_position)))
      else $error("demand write reached target early");

   // register side: writes land, reads return the stored, status or cycle word; then torque saturation and velocity lag
   chk_hrdata_idle: assert property (@(posedge ref_clk) disable iff (srst)
      ce && !(addr_ok && !hwrite) |=> hrdata == 32'h00000000)
      else $error("read data not zero outside a read");

   chk_read_vel: assert property (@(posedge ref_clk) disable iff (srst)
      ce && addr_ok && !hwrite && addr_sel == MSOB_R_VEL |=> hrdata == vel_unit_word)
      else $error("velocity word read back wrong");

   chk_read_trq: assert property (@(posedge ref_clk) disable iff (srst)
      ce && addr_ok && !hwrite && addr_sel == MSOB_R_TRQ |=>
         hrdata == {16'h0000, torque_setpoint_offset})
      else $error("torque word read back wrong");

   chk_read_cycle: assert property (@(posedge ref_clk) disable iff (srst)
      ce && addr_ok && !hwrite && addr_sel == MSOB_R_CYCLE |=> hrdata == $past(cycle_time_us))
      else $error("cycle time read back wrong");

   chk_read_status: assert property (@(posedge ref_clk) disable iff (srst)
      ce && addr_ok && !hwrite && addr_sel == MSOB_R_STATUS |=> hrdata == $past(status_word))
      else $error("status read back wrong");

   chk_write_pos: assert property (@(posedge ref_clk) disable iff (srst)
      ce && wr_act && wr_sel == MSOB_R_POS |=> position_setpoint_offset == $past(hwdata))
      else $error("position word write lost");

   chk_write_spd: assert property (@(posedge ref_clk) disable iff (srst)
      ce && wr_act && wr_sel == MSOB_R_SPD |=> speed_setpoint_offset == $past(hwdata))
      else $error("speed word write lost");

   chk_write_trq: assert property (@(posedge ref_clk) disable iff (srst)
      ce && wr_act && wr_sel == MSOB_R_TRQ |=> torque_setpoint_offset == $past(hwdata[15:0]))
      else $error("torque word write lost");

   chk_write_demand: assert property (@(posedge ref_clk) disable iff (srst)
      ce && demand_load |=> interp_demand_position == $past(hwdata))
      else $error("demand write lost");

   chk_write_pval: assert property (@(posedge ref_clk) disable iff (srst)
      ce && wr_act && wr_sel == MSOB_R_PVAL |=> interp_period_value == $past(hwdata[7:0]))
      else $error("period value write lost");

   chk_write_pexp: assert property (@(posedge ref_clk) disable iff (srst)
      ce && wr_act && wr_sel == MSOB_R_PEXP |=> interp_period_exponent == $past(hwdata[7:0]))
      else $error("period exponent write lost");

   chk_trq_sat_hi: assert property (@(posedge ref_clk) disable iff (srst)
      ce && !setpoint_in.torque[15] && !torque_setpoint_offset[15] |=> !cmd_out.torque[15])
      else $error("positive torque sum wrapped");

   chk_trq_sat_lo: assert property (@(posedge ref_clk) disable iff (srst)
      ce && setpoint_in.torque[15] && torque_setpoint_offset[15] |=> cmd_out.torque[15])
      else $error("negative torque sum wrapped");

   chk_vel_out_lag: assert property (@(posedge ref_clk) disable iff (srst)
      ce |=> vel_unit == $past(vel_unit_word[31:VEL_TIME_LSB]))
      else $error("velocity fields out of step");

endmodule
`default_nettype wire

/* File: msob_pkg.sv */
package msob_pkg;

   // register indices; the byte address is four times the index
   localparam logic [15:0] IDX_VEL_UNIT = 16'h60A9;
   localparam logic [15:0] IDX_POS_OFFSET = 16'h60B0;
   localparam logic [15:0] IDX_SPD_OFFSET = 16'h60B1;
   localparam logic [15:0] IDX_TRQ_OFFSET = 16'h60B2;
   localparam logic [15:0] IDX_DEMAND_POS = 16'h60C1;
   localparam logic [15:0] IDX_PERIOD_VAL = 16'h60C2;
   localparam logic [15:0] IDX_PERIOD_EXP = 16'h60C3;
   localparam logic [15:0] IDX_STATUS = 16'h60D0;
   localparam logic [15:0] IDX_ACTIVE_TGT = 16'h60D1;
   localparam logic [15:0] IDX_CYCLE_US = 16'h60D2;

   // reset values
   localparam logic [31:0] RST_VEL_UNIT = 32'h00B44700;
   localparam logic [31:0] RST_OFFSET32 = 32'h00000000;
   localparam logic [15:0] RST_OFFSET16 = 16'h0000;
   localparam logic [31:0] RST_DEMAND = 32'h00000000;
   localparam logic [7:0] RST_PERIOD_VAL = 8'h01;
   localparam logic [7:0] RST_PERIOD_EXP = 8'hFD;

   // velocity unit word layout
   localparam int VEL_RSVD_MSB = 7;
   localparam int VEL_TIME_LSB = 8;
   localparam int VEL_POS_LSB = 16;
   localparam int VEL_EXP_LSB = 24;
   localparam int VEL_FIELD_W = 8;

   // status register bits
   localparam int ST_PENDING = 0;
   localparam int ST_EXP_NOT_MS = 1;
   localparam int ST_RANGE_ERR = 2;

   // interpolation time base
   localparam logic signed [7:0] EXP_MS = 8'hFD;
   localparam logic signed [7:0] EXP_MIN = 8'hFA;
   localparam logic signed [7:0] EXP_MAX = 8'h00;
   localparam logic signed [7:0] EXP_US_BIAS = 8'h06;
   localparam logic [31:0] US_PER_MS = 32'h000003E8;

   localparam int unsigned ADDR_W_MIN = 18;

   typedef enum logic [3:0] {
      MSOB_R_NONE, MSOB_R_VEL, MSOB_R_POS, MSOB_R_SPD, MSOB_R_TRQ, MSOB_R_DEMAND,
      MSOB_R_PVAL, MSOB_R_PEXP, MSOB_R_STATUS, MSOB_R_ACTIVE, MSOB_R_CYCLE
   } msob_reg_t;

   // set values in, corrected commands out
   typedef struct packed {
      logic signed [31:0] position;
      logic signed [31:0] speed;
      logic signed [15:0] torque;
   } msob_setpoint_t;

   typedef struct packed {
      logic [7:0] exponent;
      logic [7:0] pos_unit;
      logic [7:0] time_unit;
   } msob_vel_unit_t;

   function automatic logic [31:0] msob_byte_addr(input logic [15:0] idx);
      return {14'h0000, idx, 2'h0};
   endfunction

endpackage

/* File: msob_sync_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module msob_sync_capture
   import msob_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic sync_pin,
   input wire logic load,
   input wire logic [31:0] demand,
   input wire logic mode_active,
   output logic [31:0] target,
   output logic target_valid,
   output logic pending
);

   logic sync_ff1, sync_ff2, sync_prev;
   logic [31:0] next_target;
   logic next_target_valid, next_pending, capture;

   // capture only on a rising sync instant while interpolating
   always_comb begin
      capture = sync_ff2 && !sync_prev && mode_active;
      next_target = capture ? demand : target;
      next_target_valid = capture;
      // a write in the capture cycle keeps pending: set wins
      next_pending = load ? 1'b1 : (capture ? 1'b0 : pending);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_ff1 <= 1'b0;
         sync_ff2 <= 1'b0;
         sync_prev <= 1'b0;
         target <= RST_DEMAND;
         target_valid <= 1'b0;
         pending <= 1'b0;
      end else if (ce) begin
         sync_ff1 <= sync_pin;
         sync_ff2 <= sync_ff1;
         sync_prev <= sync_ff2;
         target <= next_target;
         target_valid <= next_target_valid;
         pending <= next_pending;
      end
   end

   chk_target_hold: assert property (@(posedge ref_clk) disable iff (srst)
      $changed(target) |-> $past(capture)) else $error("target moved without sync");

   chk_target_mode: assert property (@(posedge ref_clk) disable iff (srst)
      target_valid |-> $past(mode_active) && target == $past(demand))
      else $error("target not taken from demand in mode");

   chk_capture_lat: assert property (@(posedge ref_clk) disable iff (srst)
      ce && sync_ff2 && !sync_prev && mode_active |=> target_valid)
      else $error("sync instant did not capture");

endmodule
`default_nettype wire

/* File: msob_cycle_time.sv */
`timescale 1ns/1ps
`default_nettype none
module msob_cycle_time
   import msob_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] period_value,
   input wire logic signed [7:0] period_exp,
   output logic [31:0] cycle_us,
   output logic range_err,
   output logic exp_not_ms
);

   logic [31:0] next_cycle_us;
   logic next_range_err, next_exp_not_ms, in_range;
   logic signed [7:0] shift;

   function automatic logic [31:0] pow10(input logic [2:0] k);
      case (k)
         3'h0: return 32'h00000001;
         3'h1: return 32'h0000000A;
         3'h2: return 32'h00000064;
         3'h3: return 32'h000003E8;
         3'h4: return 32'h00002710;
         3'h5: return 32'h000186A0;
         3'h6: return 32'h000F4240;
         default: return 32'h00000000;
      endcase
   endfunction

   // value * 10^exp seconds, in microseconds; sub-us bases are refused
   always_comb begin
      in_range = (period_exp >= EXP_MIN) && (period_exp <= EXP_MAX);
      shift = period_exp + EXP_US_BIAS;
      next_cycle_us = in_range ? 32'({24'h000000, period_value} * pow10(shift[2:0]))
                               : 32'h00000000;
      next_range_err = !in_range;
      next_exp_not_ms = (period_exp != EXP_MS);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cycle_us <= US_PER_MS;
         range_err <= 1'b0;
         exp_not_ms <= 1'b0;
      end else if (ce) begin
         cycle_us <= next_cycle_us;
         range_err <= next_range_err;
         exp_not_ms <= next_exp_not_ms;
      end
   end

   chk_cycle_ms: assert property (@(posedge ref_clk) disable iff (srst)
      ce && period_exp == EXP_MS |=>
         cycle_us == 32'({24'h000000, $past(period_value)} * US_PER_MS))
      else $error("millisecond cycle time wrong");

   chk_exp_flag: assert property (@(posedge ref_clk) disable iff (srst)
      ce |=> exp_not_ms == ($past(period_exp) != EXP_MS))
      else $error("time base flag wrong");

endmodule
`default_nettype wire

/* File: msob_sp_source.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: set values, operating mode and the sync pin
module msob_sp_source
   import msob_pkg::*;
(
   input wire logic ref_clk,
   output msob_setpoint_t setpoint_in,
   output logic ip_mode_active,
   output logic sync_pin
);
   // defined levels from time zero, nothing floats
   initial begin
      setpoint_in = '0;
      ip_mode_active = 1'b0;
      sync_pin = 1'b0;
   end
   // new set values change just after an edge
   task automatic put_sp(input msob_setpoint_t sp);
      @(posedge ref_clk);
      setpoint_in <= sp;
   endtask
   // pin held 3 cycles so the two sync flops cannot miss it
   task automatic sync_event(input logic mode);
      @(posedge ref_clk);
      ip_mode_active <= mode;
      sync_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sync_pin <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import msob_pkg::*;
   logic ref_clk = 1'b0;
   logic srst, ce, hsel, hwrite, hresp, hreadyout, ip_mode_active, sync_pin;
   logic interp_target_valid;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, interp_target, cycle_time_us;
   wire logic hready;
   msob_setpoint_t setpoint_in, cmd_out;
   msob_vel_unit_t vel_unit;
   int miscompares = 0;
   int checks_done = 0;

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;
   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   msob_bank i_msob_bank (.ref_clk(ref_clk), .srst(srst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .setpoint_in(setpoint_in), .ip_mode_active(ip_mode_active), .sync_pin(sync_pin),
      .cmd_out(cmd_out), .vel_unit(vel_unit), .interp_target(interp_target),
      .interp_target_valid(interp_target_valid), .cycle_time_us(cycle_time_us));

   msob_sp_source i_msob_sp_source (.ref_clk(ref_clk), .setpoint_in(setpoint_in),
      .ip_mode_active(ip_mode_active), .sync_pin(sync_pin));

   task automatic results();
      if (miscompares == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask

   // one single transfer; waits on ready, never on a cycle count
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {14'h0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
      check("bus response", {31'h0, hresp}, 32'h0);
   endtask

   // watch for the capture pulse, sampled after the edge settles
   task automatic wait_valid(output logic seen, output logic [31:0] tgt);
      seen = 1'b0;
      tgt = interp_target;
      repeat (8) begin
         @(posedge ref_clk);
         #1;
         if (interp_target_valid === 1'b1) begin
            seen = 1'b1;
            tgt = interp_target;
         end
      end
   endtask

   task automatic t_reset();
      logic [15:0] idx [8] = '{IDX_VEL_UNIT, IDX_POS_OFFSET, IDX_SPD_OFFSET, IDX_TRQ_OFFSET,
                               IDX_DEMAND_POS, IDX_PERIOD_VAL, IDX_PERIOD_EXP, 16'h6000};
      logic [31:0] want [8] = '{32'h00B44700, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00000001,
                                32'h000000FD, 32'h0};
      logic [31:0] rd;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, idx[i], 32'h0, rd);
         check("reset read", rd, want[i]);
      end
      #1;
      check("vel fields", {8'h00, vel_unit}, 32'h0000B447);
      check("cycle reset", cycle_time_us, 32'h000003E8);
   endtask

   task automatic t_vel();
      logic [31:0] rd;
      bus(1'b1, IDX_VEL_UNIT, 32'hFFFFFFFF, rd);
      bus(1'b0, IDX_VEL_UNIT, 32'h0, rd);
      check("vel low byte", rd, 32'hFFFFFF00);
      bus(1'b1, IDX_VEL_UNIT, 32'h12345678, rd);
      bus(1'b0, IDX_VEL_UNIT, 32'h0, rd);
      check("vel word", rd, 32'h12345600);
      #1;
      check("vel out", {8'h00, vel_unit}, 32'h00123456);
      bus(1'b1, IDX_VEL_UNIT, 32'h00B44700, rd);
   endtask

   task automatic t_offsets();
      msob_setpoint_t sp;
      logic [31:0] rd;
      bus(1'b1, IDX_POS_OFFSET, 32'h00000010, rd);
      bus(1'b1, IDX_SPD_OFFSET, 32'hFFFFFFFF, rd);
      bus(1'b1, IDX_TRQ_OFFSET, 32'h00000064, rd);
      sp.position = 32'h7FFFFFF8;
      sp.speed = 32'h00000000;
      sp.torque = 16'h7FF0;
      i_msob_sp_source.put_sp(sp);
      repeat (2) @(posedge ref_clk);
      #1;
      check("cmd position", cmd_out.position, 32'h80000008);
      check("cmd speed", cmd_out.speed, 32'hFFFFFFFF);
      check("cmd torque sat", {16'h0000, cmd_out.torque}, 32'h00007FFF);
      // negative torque offset, upper half must read back zero
      bus(1'b1, IDX_TRQ_OFFSET, 32'h0000FF9C, rd);
      bus(1'b0, IDX_TRQ_OFFSET, 32'h0, rd);
      check("trq offset", rd, 32'h0000FF9C);
      sp.torque = 16'h0100;
      i_msob_sp_source.put_sp(sp);
      repeat (2) @(posedge ref_clk);
      #1;
      check("cmd torque", {16'h0000, cmd_out.torque}, 32'h0000009C);
      // ce low freezes the command registers
      @(posedge ref_clk);
      ce <= 1'b0;
      sp.torque = 16'h0200;
      i_msob_sp_source.put_sp(sp);
      repeat (2) @(posedge ref_clk);
      #1;
      check("cmd frozen", {16'h0000, cmd_out.torque}, 32'h0000009C);
      @(posedge ref_clk);
      ce <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check("cmd resumed", {16'h0000, cmd_out.torque}, 32'h0000019C);
   endtask

   task automatic t_capture();
      logic seen;
      logic [31:0] tgt, rd;
      bus(1'b1, IDX_DEMAND_POS, 32'hFFFF8000, rd);
      repeat (3) @(posedge ref_clk);
      #1;
      check("target before sync", interp_target, 32'h0);
      bus(1'b0, IDX_STATUS, 32'h0, rd);
      check("pending set", rd, 32'h00000001);
      fork
         i_msob_sp_source.sync_event(1'b1);
         wait_valid(seen, tgt);
      join
      check("capture seen", {31'h0, seen}, 32'h1);
      check("capture value", tgt, 32'hFFFF8000);
      bus(1'b0, IDX_ACTIVE_TGT, 32'h0, rd);
      check("active target", rd, 32'hFFFF8000);
      bus(1'b0, IDX_STATUS, 32'h0, rd);
      check("pending cleared", rd, 32'h00000000);
      // sync instants outside the mode leave the target alone
      bus(1'b1, IDX_DEMAND_POS, 32'h00001234, rd);
      fork
         i_msob_sp_source.sync_event(1'b0);
         wait_valid(seen, tgt);
      join
      check("no capture", {31'h0, seen}, 32'h0);
      check("target kept", interp_target, 32'hFFFF8000);
      bus(1'b0, IDX_STATUS, 32'h0, rd);
      check("pending kept", rd, 32'h00000001);
   endtask

   task automatic t_cycle();
      logic [7:0] pv [3] = '{8'h05, 8'h05, 8'h02};
      logic [7:0] pe [3] = '{8'hFD, 8'hFA, 8'hFE};
      logic [31:0] rd, want;
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, IDX_PERIOD_VAL, {24'h0, pv[i]}, rd);
         bus(1'b1, IDX_PERIOD_EXP, {24'h0, pe[i]}, rd);
         want = {24'h0, pv[i]};
         // microseconds: value times ten to the (exponent + 6)
         for (int k = 0; k < $signed(pe[i]) + 6; k++) want = want * 10;
         bus(1'b0, IDX_CYCLE_US, 32'h0, rd);
         check("cycle reg", rd, want);
         check("cycle port", cycle_time_us, want);
      end
      // positive exponent lies outside the served range
      bus(1'b1, IDX_PERIOD_EXP, 32'h00000001, rd);
      bus(1'b0, IDX_CYCLE_US, 32'h0, rd);
      check("cycle range", rd, 32'h00000000);
      bus(1'b0, IDX_STATUS, 32'h0, rd);
      check("status flags", rd, 32'h00000007);
      bus(1'b1, IDX_PERIOD_EXP, 32'h000000FD, rd);
   endtask

   // main sequence: reset for 6 cycles, then the scenarios
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_vel();
      t_offsets();
      t_capture();
      t_cycle();
      results();
   end

   // watchdog well beyond the 150 or so cycles the tests need
   initial begin
      #2000000;
      miscompares++;
      results();
   end
endmodule
`default_nettype wire
